// ==== rtl/adc_cal_regs.svh ====
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Byte registers, each on one aligned 32-bit APB word
// Notes: Printed offsets are register indexes; byte address is index times four
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH

// Register indexes
`define IDX_SPARE_04 8'h04
`define IDX_DATA_READ_OPTIONS 8'h05
`define IDX_REFERENCE_SELECT 8'h06
`define IDX_OFFSET_LOW 8'h07
`define IDX_OFFSET_MID 8'h08
`define IDX_OFFSET_HIGH 8'h09
`define IDX_GAIN_LOW 8'h0a
`define IDX_GAIN_MID 8'h0b
`define IDX_GAIN_HIGH 8'h0c
`define IDX_SPARE_0D 8'h0d
`define IDX_SPARE_0E 8'h0e
`define IDX_CAL_STATUS 8'h20

// Field positions
`define HEADER_ENABLE_BIT 6
`define REFSEL_MSB 3
`define REFSEL_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_CLAMP_BIT 1
`define STAT_REF_BAD_BIT 2

// Reset values
`define RST_SPARE_04 8'h00
`define RST_DATA_READ_OPTIONS 8'h00
`define RST_REFERENCE_SELECT 8'h05
`define RST_OFFSET_BYTE 8'h00
`define RST_GAIN_LOW 8'h00
`define RST_GAIN_MID 8'h00
`define RST_GAIN_HIGH 8'h40
`define RST_SPARE_0D 8'hff
`define RST_SPARE_0E 8'h00

// Reference codes and scaling
`define REF_CODE_SUPPLY 4'h5
`define REF_CODE_EXTERNAL 4'ha
`define GAIN_UNITY_SHIFT 22

// Timing: calibration pipeline depth in pclk cycles
`define CAL_LATENCY 2

`endif

// ==== rtl/adc_cal_pkg.sv ====
// Purpose: Shared types for the calibration register slice
// Assumes: Constants live in adc_cal_regs.svh
// Notes: Types only
package adc_cal_pkg;
  typedef enum logic [1:0] {
    REF_SUPPLY = 2'b01,
    REF_EXTERNAL = 2'b10
  } ref_source_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_SETUP = 3'b010,
    BUS_ACCESS = 3'b100
  } bus_state_t;
endpackage

// ==== rtl/cal_datapath.sv ====
// Purpose: Offset subtraction, full-scale scaling and clamping of one sample
// Assumes: Raw sample and calibration words stable with sample_valid
// Notes: Two pipeline stages; result_valid follows sample_valid by two cycles
`include "adc_cal_regs.svh"

module cal_datapath
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic sample_valid, // Raw sample strobe
  input wire logic [23:0] raw_sample, // Raw signed result
  input wire logic [23:0] offset_word, // Signed offset
  input wire logic [23:0] full_scale_word, // Unsigned gain word
  output logic result_valid, // Calibrated sample strobe
  output logic [23:0] result, // Calibrated signed result
  output logic clamped // Result was saturated
);

  localparam logic signed [47:0] MAX_OUT = 48'sh0000_007f_ffff;
  localparam logic signed [47:0] MIN_OUT = -48'sh0000_0080_0000;

  logic signed [24:0] diff;
  logic signed [24:0] next_diff;
  logic [23:0] gain;
  logic [23:0] next_gain;
  logic stage1;
  logic next_stage1;
  logic signed [49:0] product;
  logic signed [49:0] scaled;
  logic [23:0] next_result;
  logic next_clamped;
  logic next_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: offset removed first, widened so it cannot wrap
  always_comb
  begin
    next_diff = $signed({raw_sample[23], raw_sample}) - $signed({offset_word[23], offset_word});
    next_gain = full_scale_word;
    next_stage1 = sample_valid;
  end

  // Stage 2: scale by word / 2^22, then saturate instead of wrapping
  always_comb
  begin
    product = diff * $signed({1'b0, gain});
    scaled = product >>> `GAIN_UNITY_SHIFT;
    next_valid = stage1;
    next_clamped = 1'b0;
    next_result = scaled[23:0];
    if (scaled > 50'(MAX_OUT))
    begin
      next_result = 24'h7fffff;
      next_clamped = 1'b1;
    end
    else if (scaled < 50'(MIN_OUT))
    begin
      next_result = 24'h800000;
      next_clamped = 1'b1;
    end
  end

  // Pipeline registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diff <= '0;
      gain <= '0;
      stage1 <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
      clamped <= 1'b0;
    end
    else
    begin
      diff <= next_diff;
      gain <= next_gain;
      stage1 <= next_stage1;
      result_valid <= next_valid;
      if (next_valid)
      begin
        result <= next_result;
        clamped <= next_clamped;
      end
    end
  end

endmodule // cal_datapath

// ==== rtl/adc_config_calibration_regs.sv ====
// Purpose: APB register slice for read options, reference select and calibration
// Assumes: pclk 50 MHz, one clock domain; raw samples arrive on pclk
// Notes: APB slave with one wait state; unmapped indexes read zero, misaligned or aliased addresses read the register; pslverr high
//
// Summary of operation
// - Status header byte joins each data read only when bit 6 is set.
// - Reference code 0101 selects supply, 1010 external pins; others reserved.
// - Offset is a signed 24-bit word built from three bytes.
// - Offset is subtracted first, scaling applies to the corrected value.
// - Full-scale word is unsigned 24-bit built from three bytes.
// - Result multiplied by full-scale word over 400000h; reset gives unity.
// - Offset bytes at 07h-09h, low byte first, reset zero.
// - Full-scale bytes at 0Ah-0Ch, low first, reset 00h,00h,40h.
// - Spare registers 04h and 0Eh read zero after reset; host writes zero.
// - Spare register 0Dh resets all ones; host writes only ones.
// - Read options register resets zero; bits 7 and 5:0 written zero.
// - Reference register resets 05h; upper four bits kept zero.
//
// Design decision made here: register access over APB.
`include "adc_cal_regs.svh"

module adc_config_calibration_regs
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sample_valid, // Raw conversion strobe
  input wire logic [23:0] raw_sample, // Raw conversion result
  output logic header_byte_enable, // Header byte inserted in reads
  output logic [1:0] reference_source, // One-hot or zero: 01 supply, 10 external, 00 for reserved codes
  output logic cal_valid, // Calibrated sample strobe
  output logic [23:0] cal_result // Calibrated sample
);

  logic [7:0] spare_reg_04;
  logic [7:0] data_read_options;
  logic [7:0] reference_select;
  logic [7:0] offset_bytes [3];
  logic [7:0] gain_bytes [3];
  logic [7:0] spare_reg_0d;
  logic [7:0] spare_reg_0e;
  logic clamp_seen;
  logic busy;
  logic next_clamp_seen;
  logic next_busy;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  logic [1:0] next_ref_source;
  logic access;
  logic wr;
  logic [7:0] idx;
  logic addr_ok;
  logic dp_valid;
  logic [23:0] dp_result;
  logic dp_clamped;
  logic [23:0] offset_word;
  logic [23:0] full_scale_word;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helper, used for both read and write
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i >= `IDX_SPARE_04 && i <= `IDX_SPARE_0E) || i == `IDX_CAL_STATUS;
  endfunction

  // APB phase qualifiers; low two address bits must be zero for word access
  assign access = psel && penable;
  assign wr = access && pready && pwrite && addr_ok; // Stored only at the ready edge
  assign idx = paddr[9:2];
  assign addr_ok = mapped(idx) && paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;

  // Assembled calibration words, low byte at the lowest index
  assign offset_word = {offset_bytes[2], offset_bytes[1], offset_bytes[0]};
  assign full_scale_word = {gain_bytes[2], gain_bytes[1], gain_bytes[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are stored as written so reads echo them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spare_reg_04 <= `RST_SPARE_04;
      data_read_options <= `RST_DATA_READ_OPTIONS;
      reference_select <= `RST_REFERENCE_SELECT;
      offset_bytes[0] <= `RST_OFFSET_BYTE;
      offset_bytes[1] <= `RST_OFFSET_BYTE;
      offset_bytes[2] <= `RST_OFFSET_BYTE;
      gain_bytes[0] <= `RST_GAIN_LOW;
      gain_bytes[1] <= `RST_GAIN_MID;
      gain_bytes[2] <= `RST_GAIN_HIGH;
      spare_reg_0d <= `RST_SPARE_0D;
      spare_reg_0e <= `RST_SPARE_0E;
    end
    else if (wr)
    begin
      unique case (idx)
        `IDX_SPARE_04: spare_reg_04 <= pwdata[7:0];
        `IDX_DATA_READ_OPTIONS: data_read_options <= pwdata[7:0];
        `IDX_REFERENCE_SELECT: reference_select <= pwdata[7:0];
        `IDX_OFFSET_LOW: offset_bytes[0] <= pwdata[7:0];
        `IDX_OFFSET_MID: offset_bytes[1] <= pwdata[7:0];
        `IDX_OFFSET_HIGH: offset_bytes[2] <= pwdata[7:0];
        `IDX_GAIN_LOW: gain_bytes[0] <= pwdata[7:0];
        `IDX_GAIN_MID: gain_bytes[1] <= pwdata[7:0];
        `IDX_GAIN_HIGH: gain_bytes[2] <= pwdata[7:0];
        `IDX_SPARE_0D: spare_reg_0d <= pwdata[7:0];
        `IDX_SPARE_0E: spare_reg_0e <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and answer; pready is registered so it rises one cycle into access
  always_comb
  begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    next_pready = access && !pready;
    if (access && !pready)
    begin
      next_pslverr = !addr_ok;
      if (!pwrite)
      begin
        unique case (idx)
          `IDX_SPARE_04: next_prdata = {24'h000000, spare_reg_04};
          `IDX_DATA_READ_OPTIONS: next_prdata = {24'h000000, data_read_options};
          `IDX_REFERENCE_SELECT: next_prdata = {24'h000000, reference_select};
          `IDX_OFFSET_LOW: next_prdata = {24'h000000, offset_bytes[0]};
          `IDX_OFFSET_MID: next_prdata = {24'h000000, offset_bytes[1]};
          `IDX_OFFSET_HIGH: next_prdata = {24'h000000, offset_bytes[2]};
          `IDX_GAIN_LOW: next_prdata = {24'h000000, gain_bytes[0]};
          `IDX_GAIN_MID: next_prdata = {24'h000000, gain_bytes[1]};
          `IDX_GAIN_HIGH: next_prdata = {24'h000000, gain_bytes[2]};
          `IDX_SPARE_0D: next_prdata = {24'h000000, spare_reg_0d};
          `IDX_SPARE_0E: next_prdata = {24'h000000, spare_reg_0e};
          `IDX_CAL_STATUS: next_prdata = {29'h0000000, next_ref_source == 2'b00, clamp_seen, busy};
          default: next_prdata = '0;
        endcase
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference decode; reserved codes leave no source selected
  always_comb
  begin
    unique case (reference_select[`REFSEL_MSB:`REFSEL_LSB])
      `REF_CODE_SUPPLY: next_ref_source = 2'(adc_cal_pkg::REF_SUPPLY);
      `REF_CODE_EXTERNAL: next_ref_source = 2'(adc_cal_pkg::REF_EXTERNAL);
      default: next_ref_source = 2'b00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration pipeline
  cal_datapath u_cal
  (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(sample_valid),
    .raw_sample(raw_sample),
    .offset_word(offset_word),
    .full_scale_word(full_scale_word),
    .result_valid(dp_valid),
    .result(dp_result),
    .clamped(dp_clamped)
  );

  // Sticky clamp flag cleared at the edge where the read captures it,
  // so no clamp slips in between capture and clear; a new clamp wins
  always_comb
  begin
    next_busy = sample_valid || (busy && !dp_valid);
    next_clamp_seen = clamp_seen;
    if (access && !pwrite && !pready && addr_ok && idx == `IDX_CAL_STATUS)
      next_clamp_seen = 1'b0;
    if (dp_valid && dp_clamped)
      next_clamp_seen = 1'b1;
  end

  // Outputs and status registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      header_byte_enable <= 1'b0;
      reference_source <= 2'b01;
      cal_valid <= 1'b0;
      cal_result <= '0;
      clamp_seen <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      header_byte_enable <= data_read_options[`HEADER_ENABLE_BIT];
      reference_source <= next_ref_source;
      cal_valid <= dp_valid;
      cal_result <= dp_valid ? dp_result : cal_result;
      clamp_seen <= next_clamp_seen;
      busy <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence apb_rd_s;
    psel && !penable && !pwrite;
  endsequence

  sequence apb_setup_s;
    (psel && !penable) ##1 (psel && penable);
  endsequence

  // One wait state, then a single-cycle ready pulse
  sequence apb_answer_s;
    !pready ##1 pready ##1 !pready;
  endsequence

  header_follows_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 header_byte_enable == $past(data_read_options[6]))
    else $error("header enable does not follow option bit");

  ref_decode_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    reference_select[3:0] == 4'ha |=> reference_source == 2'b10)
    else $error("external reference code not decoded");

  ref_reserved_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reference_select[3:0] != 4'h5 && reference_select[3:0] != 4'ha) |=> reference_source == 2'b00)
    else $error("reserved reference code selected a source");

  unity_gain_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_valid && full_scale_word == 24'h400000 && offset_word == 24'h000000)
    ##1 (full_scale_word == 24'h400000) |-> ##2 (cal_valid && cal_result == $past(raw_sample, 3)))
    else $error("unity gain did not pass sample unchanged");

  offset_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_valid && full_scale_word == 24'h400000 && !raw_sample[23] && !offset_word[23]
     && raw_sample[22] == 1'b0 && offset_word[22] == 1'b0) ##1 (full_scale_word == 24'h400000)
    |-> ##2 cal_result == $past(raw_sample, 3) - $past(offset_word, 3))
    else $error("offset not subtracted before scaling");

  clamp_bounds_a: assert property (@(posedge pclk) disable iff (!presetn)
    dp_valid && dp_clamped |=> (cal_result == 24'h7fffff || cal_result == 24'h800000) && clamp_seen)
    else $error("clamped result not at a rail");

  offset_reset_zero_a: assert property (@(posedge pclk)
    !presetn |-> offset_word == 24'h000000)
    else $error("offset word not zero in reset");

  gain_reset_value_a: assert property (@(posedge pclk)
    !presetn |-> full_scale_word == 24'h400000)
    else $error("full-scale word reset value wrong");

  spare_reset_a: assert property (@(posedge pclk)
    !presetn |-> spare_reg_04 == 8'h00 && spare_reg_0e == 8'h00 && spare_reg_0d == 8'hff)
    else $error("spare register reset value wrong");

  opts_ref_reset_a: assert property (@(posedge pclk)
    !presetn |-> data_read_options == 8'h00 && reference_select == 8'h05)
    else $error("option or reference reset value wrong");

  read_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_rd_s ##1 (psel && penable && paddr == 12'h018)) |=> pready && prdata == {24'h0, reference_select})
    else $error("reference read answer wrong");

  apb_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |-> apb_answer_s)
    else $error("apb answer not after one wait state");

  no_early_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> $stable(data_read_options) && $stable(reference_select))
    else $error("register changed before ready edge");

  write_on_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && paddr == 12'h014) |=> data_read_options == $past(pwdata[7:0]))
    else $error("option write did not land at ready edge");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !addr_ok) |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  clamp_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && !pready && addr_ok && idx == `IDX_CAL_STATUS && !(dp_valid && dp_clamped))
    |=> !clamp_seen)
    else $error("status read did not clear clamp flag");

endmodule // adc_config_calibration_regs

// ==== verification/apb_host_model.sv ====
// Purpose: Host processor model issuing APB transfers to the register slice
// Assumes: Caller enters xfer right after a rising pclk edge
// Notes: Released address, data and direction lines show inverted values
module apb_host_model
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  output logic psel, // APB select
  output logic penable, // APB enable
  output logic pwrite, // APB direction
  output logic [11:0] paddr, // APB byte address
  output logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////
  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale values must not look valid after release
    pwrite <= ~wr;
    paddr <= ~{2'h0, idx, 2'h0};
    pwdata <= ~{24'h0, wd};
    @(posedge pclk);
  endtask
endmodule // apb_host_model

// ==== verification/adc_config_calibration_regs_tb.sv ====
// Purpose: Self-checking bench for the calibration register slice
// Assumes: 50 MHz pclk; cal_valid shows two edges after the sample is taken
// Notes: Expected results are computed here from the scaling rules
module adc_config_calibration_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sample_valid = 1'b0;
  logic [23:0] raw_sample = 24'h0;
  logic header_byte_enable, cal_valid;
  logic [1:0] reference_source;
  logic [23:0] cal_result;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic err;

  always #10 pclk = ~pclk;

  apb_host_model u_apb_host_model (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  adc_config_calibration_regs u_adc_config_calibration_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .raw_sample(raw_sample),
    .header_byte_enable(header_byte_enable), .reference_source(reference_source),
    .cal_valid(cal_valid), .cal_result(cal_result));

  ////////////////////////////////////////////////////////////////
  // Reporting and hang guard; a few hundred cycles are expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus helpers and the reference model of the calibration
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    u_apb_host_model.xfer(1'b1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
    u_apb_host_model.xfer(1'b0, idx, 8'h00, rd, err);
    check(what, {24'h0, rd}, {24'h0, exp});
    check({what, " error"}, {31'h0, err}, {31'h0, exp_err});
  endtask

  // Floor shift, then saturate instead of wrapping
  function automatic logic [23:0] exp_cal(input logic [23:0] raw, input logic [23:0] ofs, input logic [23:0] fs);
    logic signed [50:0] p;
    p = ($signed({raw[23], raw}) - $signed({ofs[23], ofs})) * $signed({1'b0, fs});
    p = p >>> 22;
    if (p > 51'sh7fffff)
      return 24'h7fffff;
    if (p < -51'sh800000)
      return 24'h800000;
    return p[23:0];
  endfunction

  task automatic run_sample(input logic [23:0] raw, input logic [23:0] ofs, input logic [23:0] fs);
    sample_valid <= 1'b1;
    raw_sample <= raw;
    @(posedge pclk);
    sample_valid <= 1'b0;
    raw_sample <= ~raw;
    repeat (2) @(posedge pclk);
    #1 check("cal_valid", {31'h0, cal_valid}, 32'h1);
    check("cal_result", {8'h0, cal_result}, {8'h0, exp_cal(raw, ofs, fs)});
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_values;
    logic [7:0] idx [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
    logic [7:0] rst [11] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hff, 8'h00};
    check("reference_source", {30'h0, reference_source}, 32'h1);
    check("header_byte_enable", {31'h0, header_byte_enable}, 32'h0);
    for (int i = 0; i < 11; i++)
      rd_chk("reset value", idx[i], rst[i], 1'b0);
  endtask

  task automatic test_header_and_reference;
    wr(8'h05, 8'h40);
    #1 check("header on", {31'h0, header_byte_enable}, 32'h1);
    @(posedge pclk);
    rd_chk("read options", 8'h05, 8'h40, 1'b0);
    wr(8'h05, 8'h00);
    #1 check("header off", {31'h0, header_byte_enable}, 32'h0);
    @(posedge pclk);
    wr(8'h06, 8'h0a);
    #1 check("external ref", {30'h0, reference_source}, 32'h2);
    @(posedge pclk);
    rd_chk("reference_select", 8'h06, 8'h0a, 1'b0);
    wr(8'h06, 8'h05);
    #1 check("supply ref", {30'h0, reference_source}, 32'h1);
    @(posedge pclk);
  endtask

  task automatic test_spare_unmapped;
    wr(8'h0d, 8'hff);
    wr(8'h0e, 8'h00);
    rd_chk("spare 0d", 8'h0d, 8'hff, 1'b0);
    rd_chk("spare 0e", 8'h0e, 8'h00, 1'b0);
    wr(8'h30, 8'h5a);
    check("unmapped write error", {31'h0, err}, 32'h1);
    rd_chk("unmapped", 8'h30, 8'h00, 1'b1);
  endtask

  // Raw, offset and gain per case; reset words first give unity
  task automatic test_calibration;
    logic [71:0] cases [6] = '{{24'h000100, 24'h000010, 24'h800000}, {24'h000000, 24'hfffff0, 24'h400000},
      {24'h700000, 24'h000000, 24'h800000}, {24'h800000, 24'h100000, 24'h400000},
      {24'hfffff1, 24'h000000, 24'h200000}, {24'h040201, 24'h030201, 24'hc00000}};
    logic [23:0] raw, ofs, fs;
    run_sample(24'h123456, 24'h000000, 24'h400000);
    for (int i = 0; i < 6; i++)
    begin
      {raw, ofs, fs} = cases[i];
      for (logic [7:0] b = 0; b < 3; b++)
      begin
        wr(8'h07 + b, ofs[8*b +: 8]);
        wr(8'h0a + b, fs[8*b +: 8]);
      end
      run_sample(raw, ofs, fs);
    end
    rd_chk("offset low byte", 8'h07, 8'h01, 1'b0);
    rd_chk("offset high byte", 8'h09, 8'h03, 1'b0);
    rd_chk("gain high byte", 8'h0c, 8'hc0, 1'b0);
    // Sticky clamp from the rail cases, gone after the first status read
    rd_chk("clamp status", 8'h20, 8'h02, 1'b0);
    rd_chk("clamp cleared", 8'h20, 8'h00, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    presetn <= 1'b0; // Edge at time zero, so state is reset before the first clock
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset_values();
    test_header_and_reference();
    test_spare_unmapped();
    test_calibration();
    stop_test();
  end
endmodule // adc_config_calibration_regs_tb
